// ===== src/axlr_ctrl.sv
// access controller end: software AXI4-Lite slave in front, link master behind
// assumes the register map keeps AXI4-Lite signalling; one clock, synchronous reset
// Summary of operation
// - after reset rest idle without requests
// - read request wins over write request
// - write state presents address, data, strobes
// - leave write on response handshake only
// - slave error on bad write sets error
// - read state presents address, waits data handshake
// - slave error on bad read sets error
// - acknowledge returns to idle next clock
// - one clock, synchronous high reset
// - 32-bit address and data, 4-bit strobe
// - responses OKAY EXOKAY SLVERR DECERR encoded
// - read ready only when data can be taken
// - two 512-location pages, config and status
// - 32-bit registers, four-address steps
// - holes may answer with error
// - reconfiguration-port bits are reserved
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/100ps
`include "axlr_defines.svh"

module axlr_ctrl (
	input  wire logic                clk_sys,       // system clock
	input  wire logic                rst,           // synchronous reset, high
	input  wire logic [7:0]          s_axi_awaddr,  // software write address
	input  wire logic                s_axi_awvalid, // software write address valid
	output logic                     s_axi_awready, // software write address ready
	input  wire logic [31:0]         s_axi_wdata,   // software write data
	input  wire logic [3:0]          s_axi_wstrb,   // software write strobes
	input  wire logic                s_axi_wvalid,  // software write data valid
	output logic                     s_axi_wready,  // software write data ready
	output logic [1:0]               s_axi_bresp,   // software write response
	output logic                     s_axi_bvalid,  // software write response valid
	input  wire logic                s_axi_bready,  // software write response ready
	input  wire logic [7:0]          s_axi_araddr,  // software read address
	input  wire logic                s_axi_arvalid, // software read address valid
	output logic                     s_axi_arready, // software read address ready
	output logic [31:0]              s_axi_rdata,   // software read data
	output logic [1:0]               s_axi_rresp,   // software read response
	output logic                     s_axi_rvalid,  // software read valid
	input  wire logic                s_axi_rready,  // software read ready
	output logic                     irq,           // level interrupt
	axlr_if.mst                      link           // register link
);

	if (`AXLR_DW != 32 || `AXLR_AW != 32) begin : g_chk
		$error("axlr_ctrl serves only 32-bit address and data");
	end

	typedef struct packed {
		axlr_pkg::axlr_state_type st;
		logic                rd_req;
		logic                wr_req;
		logic [`AXLR_AW-1:0] addr;
		logic [`AXLR_DW-1:0] wdata;
		logic [`AXLR_SW-1:0] strb;
		logic [`AXLR_DW-1:0] rdata;
		logic                awv;
		logic                wv;
		logic                bry;
		logic                arv;
		logic                rry;
		logic                werr;
		logic                rerr;
		logic [`AXLR_NEV-1:0] irq_st;
		logic [`AXLR_NEV-1:0] irq_en;
		logic                irq;
		logic                s_awr;
		logic                s_wr;
		logic                s_aw_have;
		logic                s_w_have;
		logic [7:0]          s_awaddr;
		logic [31:0]         s_wdata;
		logic [3:0]          s_wstrb;
		logic                s_bv;
		logic [1:0]          s_bresp;
		logic                s_arr;
		logic                s_rv;
		logic [31:0]         s_rdata;
		logic [1:0]          s_rresp;
	} axlr_ctrl_type;

	axlr_ctrl_type q;
	axlr_ctrl_type d;

	always_comb begin
		logic [`AXLR_NEV-1:0] ev;
		logic [`AXLR_NEV-1:0] clr;
		ev  = '0;
		clr = '0;
		d   = q;

		// software write side: address and data in either order
		if (q.s_awr && s_axi_awvalid) begin
			d.s_aw_have = 1'b1;
			d.s_awaddr  = s_axi_awaddr;
			d.s_awr     = 1'b0;
		end
		if (q.s_wr && s_axi_wvalid) begin
			d.s_w_have = 1'b1;
			d.s_wdata  = s_axi_wdata;
			d.s_wstrb  = s_axi_wstrb;
			d.s_wr     = 1'b0;
		end
		if (q.s_aw_have && q.s_w_have && !q.s_bv) begin
			d.s_aw_have = 1'b0;
			d.s_w_have  = 1'b0;
			d.s_bv      = 1'b1;
			d.s_bresp   = `AXLR_RESP_OKAY;
			if (q.s_awaddr == `AXLR_C_CMD) begin
				if (q.s_wstrb[0] && q.s_wdata[`AXLR_CMD_WR_BIT]) begin
					d.wr_req = 1'b1;
				end
				if (q.s_wstrb[0] && q.s_wdata[`AXLR_CMD_RD_BIT]) begin
					d.rd_req = 1'b1;
				end
			end else if (q.s_awaddr == `AXLR_C_ADDR) begin
				d.addr = axlr_pkg::axlr_merge(q.addr, q.s_wdata, q.s_wstrb);
			end else if (q.s_awaddr == `AXLR_C_WDATA) begin
				d.wdata = axlr_pkg::axlr_merge(q.wdata, q.s_wdata, q.s_wstrb);
			end else if (q.s_awaddr == `AXLR_C_STRB) begin
				if (q.s_wstrb[0]) begin
					d.strb = q.s_wdata[`AXLR_SW-1:0];
				end
			end else if (q.s_awaddr == `AXLR_C_IRQ_EN) begin
				if (q.s_wstrb[0]) begin
					d.irq_en = q.s_wdata[`AXLR_NEV-1:0];
				end
			end else if (q.s_awaddr == `AXLR_C_IRQ_CLR) begin
				if (q.s_wstrb[0]) begin
					clr = q.s_wdata[`AXLR_NEV-1:0];
				end
			end else begin
				d.s_bresp = `AXLR_RESP_SLVERR;
			end
		end
		if (q.s_bv && s_axi_bready) begin
			d.s_bv  = 1'b0;
			d.s_awr = 1'b1;
			d.s_wr  = 1'b1;
		end

		// software read side
		if (q.s_arr && s_axi_arvalid) begin
			d.s_arr   = 1'b0;
			d.s_rv    = 1'b1;
			d.s_rresp = `AXLR_RESP_OKAY;
			d.s_rdata = 32'h0000_0000;
			if (s_axi_araddr == `AXLR_C_CMD) begin
				d.s_rdata[`AXLR_CMD_WR_BIT] = q.wr_req;
				d.s_rdata[`AXLR_CMD_RD_BIT] = q.rd_req;
			end else if (s_axi_araddr == `AXLR_C_ADDR) begin
				d.s_rdata = q.addr;
			end else if (s_axi_araddr == `AXLR_C_WDATA) begin
				d.s_rdata = q.wdata;
			end else if (s_axi_araddr == `AXLR_C_STRB) begin
				d.s_rdata[`AXLR_SW-1:0] = q.strb;
			end else if (s_axi_araddr == `AXLR_C_RDATA) begin
				d.s_rdata = q.rdata;
			end else if (s_axi_araddr == `AXLR_C_STATUS) begin
				d.s_rdata[2:0] = {q.rerr, q.werr, q.st != axlr_pkg::ST_IDLE};
			end else if (s_axi_araddr == `AXLR_C_IRQ_STAT) begin
				d.s_rdata[`AXLR_NEV-1:0] = q.irq_st;
			end else if (s_axi_araddr == `AXLR_C_IRQ_EN) begin
				d.s_rdata[`AXLR_NEV-1:0] = q.irq_en;
			end else if (s_axi_araddr == `AXLR_C_IRQ_CLR) begin
				d.s_rdata = 32'h0000_0000;
			end else begin
				d.s_rresp = `AXLR_RESP_SLVERR;
			end
		end
		if (q.s_rv && s_axi_rready) begin
			d.s_rv  = 1'b0;
			d.s_arr = 1'b1;
		end

		// link access machine
		case (q.st)
			axlr_pkg::ST_IDLE: begin
				if (q.rd_req) begin
					d.rd_req = 1'b0;
					d.st     = axlr_pkg::ST_READ;
					d.arv    = 1'b1;
					d.rry    = 1'b1;
				end else if (q.wr_req) begin
					d.wr_req = 1'b0;
					d.st     = axlr_pkg::ST_WRITE;
					d.awv    = 1'b1;
					d.wv     = 1'b1;
					d.bry    = 1'b1;
				end
			end
			axlr_pkg::ST_WRITE: begin
				if (q.awv && link.awready) begin
					d.awv = 1'b0;
				end
				if (q.wv && link.wready) begin
					d.wv = 1'b0;
				end
				if (link.bvalid && q.bry) begin
					d.bry  = 1'b0;
					d.st   = axlr_pkg::ST_ACK;
					d.werr = (link.bresp == `AXLR_RESP_SLVERR);
					ev[`AXLR_EV_DONE] = 1'b1;
					ev[`AXLR_EV_WERR] = (link.bresp == `AXLR_RESP_SLVERR);
				end
			end
			axlr_pkg::ST_READ: begin
				if (q.arv && link.arready) begin
					d.arv = 1'b0;
				end
				if (link.rvalid && q.rry) begin
					d.rry   = 1'b0;
					d.st    = axlr_pkg::ST_ACK;
					d.rdata = link.rdata;
					d.rerr  = (link.rresp == `AXLR_RESP_SLVERR);
					ev[`AXLR_EV_DONE] = 1'b1;
					ev[`AXLR_EV_RERR] = (link.rresp == `AXLR_RESP_SLVERR);
				end
			end
			axlr_pkg::ST_ACK: begin
				d.st = axlr_pkg::ST_IDLE;
			end
			default: begin
				d.st = axlr_pkg::ST_IDLE;
			end
		endcase

		// sticky events: a new event beats a clear in the same cycle
		d.irq_st = (q.irq_st & ~clr) | ev;
		d.irq    = |(d.irq_st & d.irq_en);
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			q       <= '0;
			q.st    <= axlr_pkg::ST_IDLE;
			q.s_awr <= 1'b1;
			q.s_wr  <= 1'b1;
			q.s_arr <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign s_axi_awready = q.s_awr;
	assign s_axi_wready  = q.s_wr;
	assign s_axi_bresp   = q.s_bresp;
	assign s_axi_bvalid  = q.s_bv;
	assign s_axi_arready = q.s_arr;
	assign s_axi_rdata   = q.s_rdata;
	assign s_axi_rresp   = q.s_rresp;
	assign s_axi_rvalid  = q.s_rv;
	assign irq           = q.irq;
	assign link.awaddr   = q.addr;
	assign link.awvalid  = q.awv;
	assign link.wdata    = q.wdata;
	assign link.wstrb    = q.strb;
	assign link.wvalid   = q.wv;
	assign link.bready   = q.bry;
	assign link.araddr   = q.addr;
	assign link.arvalid  = q.arv;
	assign link.rready   = q.rry;

endmodule

// ===== src/axlr_defines.svh
// constants shared by the register map end and the access controller end
// assumes it is included by its bare name from the package and the modules
`ifndef AXLR_DEFINES_SVH
`define AXLR_DEFINES_SVH

`define AXLR_AW           32
`define AXLR_DW           32
`define AXLR_SW           4
`define AXLR_RESP_OKAY    2'h0
`define AXLR_RESP_EXOKAY  2'h1
`define AXLR_RESP_SLVERR  2'h2
`define AXLR_RESP_DECERR  2'h3
`define AXLR_CFG_BASE     32'h0000_0000
`define AXLR_STAT_BASE    32'h0000_0200
`define AXLR_PAGE_SIZE    32'h0000_0200
`define AXLR_NREGS        20

`define AXLR_OFF_CORE_VERSION   32'h0000_0000
`define AXLR_OFF_XCVR_RESET     32'h0000_0004
`define AXLR_OFF_CORE_RESET     32'h0000_0008
`define AXLR_OFF_OP_MODE        32'h0000_000C
`define AXLR_OFF_TX_CFG_1       32'h0000_0010
`define AXLR_OFF_RX_CFG_1       32'h0000_0018
`define AXLR_OFF_TX_PAR_OVR     32'h0000_002C
`define AXLR_OFF_TX_PAUSE_CTL_1 32'h0000_0030
`define AXLR_OFF_TX_PAUSE_REF_1 32'h0000_0034
`define AXLR_OFF_TX_PAUSE_REF_2 32'h0000_0038
`define AXLR_OFF_TX_PAUSE_REF_3 32'h0000_003C
`define AXLR_OFF_TX_PAUSE_REF_4 32'h0000_0040
`define AXLR_OFF_TX_PAUSE_REF_5 32'h0000_0044
`define AXLR_OFF_TX_PAUSE_QNT_1 32'h0000_0048
`define AXLR_OFF_TX_PAUSE_QNT_2 32'h0000_004C
`define AXLR_OFF_TX_PAUSE_QNT_3 32'h0000_0050
`define AXLR_OFF_TX_PAUSE_QNT_4 32'h0000_0054
`define AXLR_OFF_TX_PAUSE_QNT_5 32'h0000_0058
`define AXLR_OFF_RX_PAUSE_CTL_1 32'h0000_0084
`define AXLR_OFF_RX_PAUSE_CTL_2 32'h0000_0088
`define AXLR_OFF_STATUS         32'h0000_0200

`define AXLR_RESET_WORD   32'h0000_0000

// controller registers seen by software
`define AXLR_C_CMD        8'h00
`define AXLR_C_ADDR       8'h04
`define AXLR_C_WDATA      8'h08
`define AXLR_C_STRB       8'h0C
`define AXLR_C_RDATA      8'h10
`define AXLR_C_STATUS     8'h14
`define AXLR_C_IRQ_STAT   8'h18
`define AXLR_C_IRQ_EN     8'h1C
`define AXLR_C_IRQ_CLR    8'h20
`define AXLR_CMD_WR_BIT   0
`define AXLR_CMD_RD_BIT   1
`define AXLR_EV_DONE      0
`define AXLR_EV_WERR      1
`define AXLR_EV_RERR      2
`define AXLR_NEV          3

`endif

// ===== src/axlr_if.sv
// AXI4-Lite link between the access controller and the register map
// assumes one clock; the testbench joins both ends through this interface
`timescale 1ns/100ps
`include "axlr_defines.svh"

interface axlr_if;
	logic [`AXLR_AW-1:0] awaddr;
	logic                awvalid;
	logic                awready;
	logic [`AXLR_DW-1:0] wdata;
	logic [`AXLR_SW-1:0] wstrb;
	logic                wvalid;
	logic                wready;
	logic [1:0]          bresp;
	logic                bvalid;
	logic                bready;
	logic [`AXLR_AW-1:0] araddr;
	logic                arvalid;
	logic                arready;
	logic [`AXLR_DW-1:0] rdata;
	logic [1:0]          rresp;
	logic                rvalid;
	logic                rready;

	modport mst (output awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready,
		input awready, wready, bresp, bvalid, arready, rdata, rresp, rvalid);
	modport dev (input awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready,
		output awready, wready, bresp, bvalid, arready, rdata, rresp, rvalid);
endinterface

// ===== src/axlr_pkg.sv
// types and helpers shared by both ends of the register access link
// assumes axlr_defines.svh is on the include path
`include "axlr_defines.svh"

package axlr_pkg;

	typedef enum logic [3:0] {
		ST_IDLE  = 4'h1,
		ST_WRITE = 4'h2,
		ST_READ  = 4'h4,
		ST_ACK   = 4'h8
	} axlr_state_type;

	typedef logic [`AXLR_DW-1:0] axlr_word_type;

	// byte-lane merge of a write into a stored word
	function automatic axlr_word_type axlr_merge(axlr_word_type old_w, axlr_word_type new_w,
			logic [`AXLR_SW-1:0] strb);
		axlr_word_type r;
		r = old_w;
		for (int i = 0; i < `AXLR_SW; i++) begin
			if (strb[i]) begin
				r[8*i +: 8] = new_w[8*i +: 8];
			end
		end
		return r;
	endfunction

endpackage

// ===== src/axlr_regmap.sv
// register map end: AXI4-Lite slave holding the configuration page
// assumes the master keeps AXI4-Lite signalling; one clock, synchronous reset
`timescale 1ns/100ps
`include "axlr_defines.svh"

module axlr_regmap #(
	parameter logic [31:0] VERSION   = 32'h0000_0100, // arbitrary value
	parameter logic [31:0] RSVD_MASK = 32'h0000_0000  // bits owned by the reconfiguration port
) (
	input  wire logic                          clk_sys,    // system clock
	input  wire logic                          rst,        // synchronous reset, high
	axlr_if.dev                                link,       // register link
	input  wire logic [`AXLR_DW-1:0]           status_word, // word shown at status page base
	output logic [`AXLR_NREGS-1:0][`AXLR_DW-1:0] cfg_words  // configuration words
);

	localparam logic [31:0] OFFS [`AXLR_NREGS] = '{
		`AXLR_OFF_CORE_VERSION, `AXLR_OFF_XCVR_RESET, `AXLR_OFF_CORE_RESET,
		`AXLR_OFF_OP_MODE, `AXLR_OFF_TX_CFG_1, `AXLR_OFF_RX_CFG_1, `AXLR_OFF_TX_PAR_OVR,
		`AXLR_OFF_TX_PAUSE_CTL_1, `AXLR_OFF_TX_PAUSE_REF_1, `AXLR_OFF_TX_PAUSE_REF_2,
		`AXLR_OFF_TX_PAUSE_REF_3, `AXLR_OFF_TX_PAUSE_REF_4, `AXLR_OFF_TX_PAUSE_REF_5,
		`AXLR_OFF_TX_PAUSE_QNT_1, `AXLR_OFF_TX_PAUSE_QNT_2, `AXLR_OFF_TX_PAUSE_QNT_3,
		`AXLR_OFF_TX_PAUSE_QNT_4, `AXLR_OFF_TX_PAUSE_QNT_5, `AXLR_OFF_RX_PAUSE_CTL_1,
		`AXLR_OFF_RX_PAUSE_CTL_2};

	if (`AXLR_DW != 32 || `AXLR_SW != 4) begin : g_chk
		$error("axlr_regmap serves only 32-bit data");
	end

	typedef struct packed {
		logic [`AXLR_NREGS-1:0][`AXLR_DW-1:0] regs;
		logic                aw_have;
		logic                w_have;
		logic [`AXLR_AW-1:0] awaddr;
		logic [`AXLR_DW-1:0] wdata;
		logic [`AXLR_SW-1:0] wstrb;
		logic                awr;
		logic                wr;
		logic                bv;
		logic [1:0]          bresp;
		logic                arr;
		logic                rv;
		logic [`AXLR_DW-1:0] rdata;
		logic [1:0]          rresp;
	} axlr_dev_type;

	axlr_dev_type q;
	axlr_dev_type d;

	// {hit, index}; holes and the rest of both pages miss
	function automatic logic [5:0] axlr_find(logic [`AXLR_AW-1:0] a);
		logic [5:0] r;
		r = 6'h00;
		for (int i = 0; i < `AXLR_NREGS; i++) begin
			if (a == (`AXLR_CFG_BASE + OFFS[i])) begin
				r = {1'b1, 5'(i)};
			end
		end
		return r;
	endfunction

	always_comb begin
		logic [5:0] f;
		f = 6'h00;
		d = q;
		if (q.awr && link.awvalid) begin
			d.aw_have = 1'b1;
			d.awaddr  = link.awaddr;
			d.awr     = 1'b0;
		end
		if (q.wr && link.wvalid) begin
			d.w_have = 1'b1;
			d.wdata  = link.wdata;
			d.wstrb  = link.wstrb;
			d.wr     = 1'b0;
		end
		if (q.aw_have && q.w_have && !q.bv) begin
			f = axlr_find(q.awaddr);
			d.aw_have = 1'b0;
			d.w_have  = 1'b0;
			d.bv      = 1'b1;
			if (f[5] && f[4:0] != 5'h00) begin
				d.regs[f[4:0]] = axlr_pkg::axlr_merge(q.regs[f[4:0]], q.wdata, q.wstrb)
					& ~RSVD_MASK;
				d.bresp = `AXLR_RESP_OKAY;
			end else begin
				d.bresp = `AXLR_RESP_SLVERR;
			end
		end
		if (q.bv && link.bready) begin
			d.bv  = 1'b0;
			d.awr = 1'b1;
			d.wr  = 1'b1;
		end
		if (q.arr && link.arvalid) begin
			f = axlr_find(link.araddr);
			d.arr = 1'b0;
			d.rv  = 1'b1;
			d.rresp = `AXLR_RESP_OKAY;
			if (f[5] && f[4:0] == 5'h00) begin
				d.rdata = VERSION;
			end else if (f[5]) begin
				d.rdata = q.regs[f[4:0]];
			end else if (link.araddr == `AXLR_STAT_BASE + `AXLR_OFF_STATUS - `AXLR_PAGE_SIZE) begin
				d.rdata = status_word;
			end else begin
				d.rdata = `AXLR_RESET_WORD;
				d.rresp = `AXLR_RESP_SLVERR;
			end
		end
		if (q.rv && link.rready) begin
			d.rv  = 1'b0;
			d.arr = 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			q <= '0;
			q.awr <= 1'b1;
			q.wr  <= 1'b1;
			q.arr <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign link.awready = q.awr;
	assign link.wready  = q.wr;
	assign link.bvalid  = q.bv;
	assign link.bresp   = q.bresp;
	assign link.arready = q.arr;
	assign link.rvalid  = q.rv;
	assign link.rdata   = q.rdata;
	assign link.rresp   = q.rresp;
	assign cfg_words    = q.regs;

endmodule

// ===== verification/axi_lite_register_access_tb.sv
// self-checking bench: software bus drives the controller, which reaches the register map
// assumes both ends meet in axlr_if; expected results are queued and compared by a monitor
`timescale 1ns/100ps
`include "axlr_defines.svh"

`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin failures++; \
	$display("MISMATCH %s expected %h seen %h", nm, e, g); end end

module axi_lite_register_access_tb;
	localparam logic [31:0] VER = 32'h0000_0A51; // arbitrary value
	localparam logic [31:0] RSV = 32'h8000_0001;
	logic              clk_sys = 1'b0;
	logic              rst = 1'b1;
	logic [7:0]        s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0]       s_axi_wdata = 32'h0, status_i = 32'h0, s_axi_rdata;
	logic [3:0]        s_axi_wstrb = 4'h0;
	logic              s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic              s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
	logic [1:0]        s_axi_bresp, s_axi_rresp;
	logic [19:0][31:0] cfg_o;
	logic [31:0]       seed = 32'h0001_1AC8, mdl [20], d;
	logic [7:0]        offs [20] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h18, 8'h2C, 8'h30,
		8'h34, 8'h38, 8'h3C, 8'h40, 8'h44, 8'h48, 8'h4C, 8'h50, 8'h54, 8'h58, 8'h84, 8'h88};
	logic [34:0]       rq [$], rx;
	logic [1:0]        bq [$], bx;
	logic              ord [$], ar_q = 1'b0, aw_q = 1'b0;
	logic [3:0]        st;
	int                failures = 0, checks_done = 0;

	axlr_if link();
	axlr_regmap #(.VERSION(VER), .RSVD_MASK(RSV)) axlr_regmap_inst (.clk_sys(clk_sys),
		.rst(rst), .link(link), .status_word(status_i), .cfg_words(cfg_o));
	axlr_ctrl axlr_ctrl_inst (.clk_sys(clk_sys), .rst(rst), .irq(irq), .link(link),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready));
	axlr_link_checker axlr_link_checker_inst (.clk_sys(clk_sys), .rst(rst),
		.awaddr(link.awaddr), .awvalid(link.awvalid), .awready(link.awready),
		.wdata(link.wdata), .wstrb(link.wstrb), .wvalid(link.wvalid), .wready(link.wready),
		.bresp(link.bresp), .bvalid(link.bvalid), .bready(link.bready),
		.araddr(link.araddr), .arvalid(link.arvalid), .arready(link.arready),
		.rdata(link.rdata), .rresp(link.rresp), .rvalid(link.rvalid), .rready(link.rready));

	always #5 clk_sys = ~clk_sys;

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic logic [31:0] mrg(logic [31:0] o, logic [31:0] n, logic [3:0] s);
		for (int i = 0; i < 4; i++) if (s[i]) o[8*i +: 8] = n[8*i +: 8];
		return o & ~RSV;
	endfunction

	// results are compared in the order they were requested
	always @(posedge clk_sys) begin
		ar_q <= link.arvalid;
		aw_q <= link.awvalid;
		if (link.arvalid && !ar_q) ord.push_back(1'b1);
		if (link.awvalid && !aw_q) ord.push_back(1'b0);
		if (s_axi_bvalid && s_axi_bready) begin
			bx = bq.pop_front();
			`CHK("bresp", bx, s_axi_bresp)
		end
		if (s_axi_rvalid && s_axi_rready) begin
			rx = rq.pop_front();
			`CHK("rresp", rx[33:32], s_axi_rresp)
			if (rx[34]) `CHK("rdata", rx[31:0], s_axi_rdata)
		end
	end

	task automatic sw_wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] r);
		bq.push_back(r);
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_wstrb <= 4'hF;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!(s_axi_bvalid && s_axi_bready));
		s_axi_bready <= 1'b0;
	endtask

	task automatic sw_rd(input logic [7:0] a, input logic [31:0] v, input logic [1:0] r,
			input logic cd);
		rq.push_back({cd, r, v});
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!(s_axi_rvalid && s_axi_rready));
		s_axi_rready <= 1'b0;
	endtask

	task automatic setup(input logic [31:0] a, input logic [31:0] v, input logic [3:0] s);
		sw_wr(`AXLR_C_ADDR, a, 2'h0);
		sw_wr(`AXLR_C_WDATA, v, 2'h0);
		sw_wr(`AXLR_C_STRB, {28'h0, s}, 2'h0);
	endtask

	// one link transfer: command, wait for the interrupt, check events, clear them
	task automatic go(input logic [31:0] a, input logic [31:0] v, input logic [3:0] s,
			input logic [1:0] c, input logic [2:0] ev);
		setup(a, v, s);
		sw_wr(`AXLR_C_CMD, {30'h0, c}, 2'h0);
		while (irq !== 1'b1) @(posedge clk_sys);
		sw_rd(`AXLR_C_IRQ_STAT, {29'h0, ev}, 2'h0, 1'b1);
		sw_wr(`AXLR_C_IRQ_CLR, 32'h7, 2'h0);
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk_sys);
		failures++;
		finish_test();
	end

	initial begin
		for (int i = 0; i < 20; i++) mdl[i] = 32'h0;
		repeat (16) @(posedge clk_sys);
		rst <= 1'b0;
		status_i <= rnd();
		for (int i = 0; i < 20; i++) `CHK("cfg reset", 32'h0, cfg_o[i])
		sw_rd(`AXLR_C_STATUS, 32'h0, 2'h0, 1'b1);
		sw_wr(8'h24, 32'h1, 2'h2);
		sw_rd(8'h24, 32'h0, 2'h2, 1'b0);
		$display("TEST reset done");
		// interrupt raised while masked, then enabled and cleared
		d = rnd();
		setup(32'h10, d, 4'hF);
		sw_wr(`AXLR_C_IRQ_EN, 32'h0, 2'h0);
		sw_wr(`AXLR_C_CMD, 32'h1, 2'h0);
		repeat (20) @(posedge clk_sys);
		`CHK("irq masked", 1'b0, irq)
		sw_rd(`AXLR_C_IRQ_STAT, 32'h1, 2'h0, 1'b1);
		sw_wr(`AXLR_C_IRQ_EN, 32'h7, 2'h0);
		repeat (2) @(posedge clk_sys);
		`CHK("irq raised", 1'b1, irq)
		sw_wr(`AXLR_C_IRQ_CLR, 32'h7, 2'h0);
		repeat (2) @(posedge clk_sys);
		`CHK("irq cleared", 1'b0, irq)
		mdl[4] = d & ~RSV;
		`CHK("cfg write", mdl[4], cfg_o[4])
		$display("TEST interrupt done");
		for (int i = 1; i < 20; i++) begin
			d = rnd();
			st = d[7:4];
			go({24'h0, offs[i]}, d, st, 2'h1, 3'h1);
			mdl[i] = mrg(mdl[i], d, st);
			`CHK("cfg map", mdl[i], cfg_o[i])
			go({24'h0, offs[i]}, 32'h0, 4'h0, 2'h2, 3'h1);
			sw_rd(`AXLR_C_RDATA, mdl[i], 2'h0, 1'b1);
		end
		$display("TEST map done");
		go(32'h0, 32'h0, 4'h0, 2'h2, 3'h1);
		sw_rd(`AXLR_C_RDATA, VER, 2'h0, 1'b1);
		go(32'h200, 32'h0, 4'h0, 2'h2, 3'h1);
		sw_rd(`AXLR_C_RDATA, status_i, 2'h0, 1'b1);
		$display("TEST read done");
		go(32'h0, rnd(), 4'hF, 2'h1, 3'h3);
		`CHK("version slot", 32'h0, cfg_o[0])
		sw_rd(`AXLR_C_STATUS, 32'h2, 2'h0, 1'b1);
		go(32'h14, rnd(), 4'hF, 2'h1, 3'h3);
		go(32'h200, rnd(), 4'hF, 2'h1, 3'h3);
		go(32'h14, 32'h0, 4'h0, 2'h2, 3'h5);
		sw_rd(`AXLR_C_RDATA, 32'h0, 2'h0, 1'b1);
		sw_rd(`AXLR_C_STATUS, 32'h6, 2'h0, 1'b1);
		$display("TEST errors done");
		// both commands at once: the read must go first and see the old word
		d = rnd();
		setup(32'h18, d, 4'hF);
		ord.delete();
		sw_wr(`AXLR_C_CMD, 32'h3, 2'h0);
		while (ord.size() < 2) @(posedge clk_sys);
		repeat (8) @(posedge clk_sys);
		`CHK("read first", 1'b1, ord[0])
		sw_rd(`AXLR_C_RDATA, mdl[5], 2'h0, 1'b1);
		mdl[5] = d & ~RSV;
		`CHK("cfg after both", mdl[5], cfg_o[5])
		sw_rd(`AXLR_C_STATUS, 32'h0, 2'h0, 1'b1);
		sw_wr(`AXLR_C_IRQ_CLR, 32'h7, 2'h0);
		$display("TEST priority done");
		@(posedge clk_sys);
		rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		`CHK("cfg second reset", 32'h0, cfg_o[4])
		`CHK("irq second reset", 1'b0, irq)
		sw_rd(`AXLR_C_IRQ_STAT, 32'h0, 2'h0, 1'b1);
		$display("TEST second reset done");
		finish_test();
	end
endmodule

// ===== verification/axlr_link_checker.sv
// concurrent checks on the register link between the controller and the register map
// assumes the testbench hands it every link signal plus the clock and reset
`timescale 1ns/100ps

module axlr_link_checker (
	input wire logic        clk_sys, // system clock
	input wire logic        rst,     // synchronous reset, high
	input wire logic [31:0] awaddr,  // write address
	input wire logic        awvalid, // write address valid
	input wire logic        awready, // write address ready
	input wire logic [31:0] wdata,   // write data
	input wire logic [3:0]  wstrb,   // write strobes
	input wire logic        wvalid,  // write data valid
	input wire logic        wready,  // write data ready
	input wire logic [1:0]  bresp,   // write response
	input wire logic        bvalid,  // write response valid
	input wire logic        bready,  // write response ready
	input wire logic [31:0] araddr,  // read address
	input wire logic        arvalid, // read address valid
	input wire logic        arready, // read address ready
	input wire logic [31:0] rdata,   // read data
	input wire logic [1:0]  rresp,   // read response
	input wire logic        rvalid,  // read valid
	input wire logic        rready   // read ready
);
	default clocking dck @(posedge clk_sys); endclocking
	default disable iff (rst);

	aw_take_a: assert property (awvalid && awready |=> !awvalid && !awready)
		else $error("write address not released after it was taken");
	w_take_a: assert property (wvalid && wready |=> !wvalid && !wready)
		else $error("write data not released after it was taken");
	wr_start_a: assert property ($rose(awvalid) |-> wvalid && bready && !arvalid)
		else $error("write did not start with data and response ready");
	rd_start_a: assert property ($rose(arvalid) |-> rready && !awvalid)
		else $error("read started without read ready");
	b_wait_a: assert property (bready && !bvalid |=> bready)
		else $error("response ready dropped before the response");
	b_end_a: assert property (bvalid && bready |=> (!bready && !awvalid && !arvalid)[*2])
		else $error("no acknowledge and idle after write response");
	r_end_a: assert property (rvalid && rready |=> (!rready && !arvalid && !awvalid)[*2])
		else $error("no acknowledge and idle after read data");
	r_free_a: assert property (rvalid && rready |=> !rvalid && arready)
		else $error("read answer not withdrawn after it was taken");
	wr_err_a: assert property (awvalid && awready && awaddr == 32'h0000_0000
		|-> ##[1:4] bvalid && bresp == 2'h2) else $error("write to version slot not refused");
	rd_err_a: assert property (arvalid && arready && araddr == 32'h0000_0014
		|-> ##[1:3] rvalid && rresp == 2'h2 && rdata == 32'h0) else $error("hole read not refused");
	rst_idle_a: assert property (disable iff (1'b0) rst |=> !awvalid && !arvalid && !bvalid && !rvalid)
		else $error("link not quiet after reset");
endmodule
